// ==== bench/idc_far_model.sv ====
// Far-side model: PC/PCI arbiter and ISA DMA slot devices
// Assumes the block's request and acknowledge pins on one clock
`timescale 1ns/1ps
module idc_far_model
(
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_nrst,
    // Pace and slot wishes
    input  wire logic [7:0] i_want,
    input  wire logic       i_slow,
    // Block side
    input  wire logic       i_req_n,
    input  wire logic [7:0] i_dack_n,
    output logic            o_grant_n,
    output logic [7:0]      o_dreq
);
    logic [3:0] cnt;
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt <= 4'h0;
            o_grant_n <= 1'b1;
            o_dreq <= 8'h00;
        end
        else
        begin
            // Slot devices hold requests until acknowledged
            o_dreq <= (o_dreq | i_want) & i_dack_n;
            // Grant after a short or long wait, dropped with the request
            cnt <= i_req_n ? 4'h0 : cnt + 4'h1;
            o_grant_n <= i_req_n | (cnt < (i_slow ? 4'h6 : 4'h1));
        end
    end
endmodule

// ==== bench/idc_top_chk.sv ====
// Concurrent checks on the ports of idc_top
// Assumes the bind below, one clock domain
`timescale 1ns/1ps
module idc_top_chk
(
    input wire logic       i_core_clk,
    input wire logic       i_nrst,
    input wire logic       i_prohibit,
    input wire logic [7:0] o_dack_n,
    input wire logic       o_tc,
    input wire logic       o_aen,
    input wire logic       o_io_chk_err,
    input wire logic       o_pcpci_bus_request_n,
    input wire logic       o_devsel_n,
    input wire logic       o_bios_pos,
    input wire logic       o_serirq,
    input wire logic       o_serirq_oe
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    property p_aen; o_aen |-> $onehot(~o_dack_n); endproperty
    a_aen: assert property (p_aen) else $error("aen without one dack");
    property p_dack; $onehot0(~o_dack_n) && o_dack_n[4]; endproperty
    a_dack: assert property (p_dack) else $error("bad dack set");
    property p_tc; o_tc |-> o_aen; endproperty
    a_tc: assert property (p_tc) else $error("tc outside transfer");
    property p_req; $rose(o_aen) |-> !$past(o_pcpci_bus_request_n); endproperty
    a_req: assert property (p_req) else $error("transfer without request");
    property p_dsel; !o_devsel_n |=> o_devsel_n; endproperty
    a_dsel: assert property (p_dsel) else $error("devsel too long");
    property p_proh;
        $fell(o_devsel_n) && !o_bios_pos |-> !$past(i_prohibit, 3);
    endproperty
    a_proh: assert property (p_proh) else $error("claim while inhibited");
    property p_strap; $rose(o_bios_pos) |=> o_bios_pos [*8]; endproperty
    a_strap: assert property (p_strap) else $error("strap mode lost");
    property p_chk; o_io_chk_err |=> o_io_chk_err; endproperty
    a_chk: assert property (p_chk) else $error("channel error lost");
    property p_sq; !o_serirq |-> o_serirq_oe; endproperty
    a_sq: assert property (p_sq) else $error("serirq low undriven");
    c_tc: cover property (o_tc);
    c_dsel: cover property ($fell(o_devsel_n));
    c_sq: cover property (o_serirq_oe);
endmodule
bind idc_top idc_top_chk idc_top_chk_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_prohibit(i_prohibit), .o_dack_n(o_dack_n), .o_tc(o_tc), .o_aen(o_aen),
    .o_io_chk_err(o_io_chk_err), .o_pcpci_bus_request_n(o_pcpci_bus_request_n),
    .o_devsel_n(o_devsel_n), .o_bios_pos(o_bios_pos), .o_serirq(o_serirq),
    .o_serirq_oe(o_serirq_oe));

// ==== bench/isa_dma_and_decode_control_tb.sv ====
// Self-checking bench for idc_top
// Assumes the far-side model and checker files
`timescale 1ns/1ps
module isa_dma_and_decode_control_tb;
    import idc_pkg::*;
    logic i_core_clk, i_nrst = 1'b0, i_isa_master_req = 1'b0, i_last_xfer = 1'b0;
    logic i_xfer_done = 1'b0, i_io_chk_n = 1'b1, i_prohibit = 1'b1, i_ale = 1'b0;
    logic i_bios_positive_decode_strap_n = 1'b1, sq_drv = 1'b1, slow = 1'b0;
    logic [7:0] want = 8'h00, i_dma_req, o_dack_n, dprev = 8'hFF;
    logic [15:0] i_irq = 16'h0000;
    idc_pci_t i_pci = '0;
    logic i_pcpci_bus_grant_n, o_tc, o_aen, o_io_chk_err, o_pcpci_bus_request_n;
    logic o_devsel_n, o_bios_pos, o_test_mode, o_serirq, o_serirq_oe, i_serirq;
    logic [7:0] expq[$];
    logic [31:0] rnd = 32'hE98D;
    int n_fail = 0;
    int samples_checked = 0;
    assign i_serirq = o_serirq_oe ? o_serirq : sq_drv;
    idc_top idc_top_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_dma_req(i_dma_req),
        .i_isa_master_req(i_isa_master_req), .i_last_xfer(i_last_xfer),
        .i_xfer_done(i_xfer_done), .i_io_chk_n(i_io_chk_n), .i_irq(i_irq),
        .o_dack_n(o_dack_n), .o_tc(o_tc), .o_aen(o_aen), .o_io_chk_err(o_io_chk_err),
        .o_pcpci_bus_request_n(o_pcpci_bus_request_n),
        .i_pcpci_bus_grant_n(i_pcpci_bus_grant_n), .i_pci(i_pci), .i_prohibit(i_prohibit),
        .i_bios_positive_decode_strap_n(i_bios_positive_decode_strap_n), .i_ale(i_ale),
        .o_devsel_n(o_devsel_n), .o_bios_pos(o_bios_pos), .o_test_mode(o_test_mode),
        .i_serirq(i_serirq), .o_serirq(o_serirq), .o_serirq_oe(o_serirq_oe));
    idc_far_model idc_far_model_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_want(want), .i_slow(slow), .i_req_n(o_pcpci_bus_request_n),
        .i_dack_n(o_dack_n), .o_grant_n(i_pcpci_bus_grant_n), .o_dreq(i_dma_req));
    initial
    begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Acknowledges compared against the queued channel order
    always @(posedge i_core_clk)
    begin
        if (i_nrst && o_dack_n !== dprev && o_dack_n !== 8'hFF)
            check(o_dack_n, expq.size() ? expq.pop_front() : 8'h00, "dack");
        dprev <= o_dack_n;
    end
    task automatic do_reset(input logic s);
        i_nrst <= 1'b0;
        i_bios_positive_decode_strap_n <= s;
        repeat (20) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        i_ale <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        i_ale <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        check(o_bios_pos, !s, "strap");
        check(o_test_mode, i_prohibit, "test mode");
    endtask
    task automatic cyc(input logic [31:0] a, input logic clm, input logic exp);
        logic seen = 1'b0;
        i_pci <= '{frame: 1'b1, claimed: clm, addr: a};
        repeat (8)
        begin
            @(posedge i_core_clk);
            #1 if (o_devsel_n === 1'b0) seen = 1'b1;
        end
        i_pci <= '0;
        repeat (2) @(posedge i_core_clk);
        check(seen, exp, "claim");
    endtask
    task automatic xfer(input logic lt);
        for (int k = 0; k < 40 && o_dack_n === 8'hFF; k++) @(posedge i_core_clk);
        i_last_xfer <= lt;
        repeat (2) @(posedge i_core_clk);
        check(o_tc, lt, "tc");
        check(o_aen, 1, "aen");
        i_xfer_done <= 1'b1;
        @(posedge i_core_clk);
        i_xfer_done <= 1'b0;
        i_last_xfer <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        check(o_dack_n, 8'hFF, "dack release");
    endtask
    task automatic dma(input logic [7:0] m, input logic lt);
        rnd = lfsr(rnd);
        slow <= rnd[0];
        for (int i = 0; i < 8; i++)
            if (m[i])
                expq.push_back(~(8'h01 << i));
        want <= m;
        @(posedge i_core_clk);
        want <= 8'h00;
        for (int i = 0; i < 8; i++)
            if (m[i])
                xfer(lt);
    endtask
    initial
    begin
        do_reset(1'b1);
        cyc(32'h000C8000, 1'b0, 1'b0);
        cyc(32'hFFF12340, 1'b0, 1'b0);
        i_prohibit <= 1'b0;
        cyc(32'h000C8000, 1'b0, 1'b1);
        cyc(32'h000C8000, 1'b1, 1'b0);
        cyc(32'hFFF12340, 1'b1, 1'b0);
        check(o_io_chk_err, 0, "no channel error");
        $display("decode test done");
        for (int c = 0; c < 8; c++)
            if (c != 4)
                dma(8'h01 << c, c[0]);
        dma(8'h22, 1'b1);
        want <= 8'h10;
        @(posedge i_core_clk);
        want <= 8'h00;
        repeat (8) @(posedge i_core_clk);
        check(o_pcpci_bus_request_n, 1, "channel 4 ignored");
        slow <= 1'b1;
        i_isa_master_req <= 1'b1;
        repeat (5) @(posedge i_core_clk);
        check(o_pcpci_bus_request_n, 0, "master request");
        i_isa_master_req <= 1'b0;
        $display("dma test done");
        rnd = lfsr(rnd);
        i_irq <= (rnd[15:0] & 16'hDEF8) | 16'h0008;
        i_io_chk_n <= 1'b0;
        sq_drv <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        i_io_chk_n <= 1'b1;
        sq_drv <= 1'b1;
        check(o_io_chk_err, 1, "channel error");
        for (int k = 0; k < 80 && o_serirq_oe !== 1'b1; k++) @(posedge i_core_clk);
        check(o_serirq_oe, 1, "serial irq drive");
        check(o_serirq, 0, "serial irq low");
        $display("irq test done");
        i_prohibit <= 1'b1;
        do_reset(1'b0);
        cyc(32'hFFF12340, 1'b0, 1'b1);
        cyc(32'hFFF12340, 1'b1, 1'b1);
        cyc(32'h000C8000, 1'b0, 1'b1);
        cyc(32'h000C8000, 1'b1, 1'b0);
        $display("bios test done");
        check(expq.size(), 0, "acks outstanding");
        give_verdict();
    end
    // Watchdog well past the expected run of a few hundred cycles
    initial
    begin
        #200000;
        n_fail++;
        give_verdict();
    end
endmodule

// ==== logic/idc_defs.svh ====
// Constants for the ISA DMA and decode control block
// Assumes inclusion by the top module only
`ifndef IDC_DEFS_SVH
`define IDC_DEFS_SVH

// ----------------------------------------------------------------
// Channel and IRQ masks
// ----------------------------------------------------------------
`define IDC_DMA_CH_MASK     8'hEF
`define IDC_IRQ_MASK        16'hDEF8
`define IDC_DMA_NONE        3'h4

// ----------------------------------------------------------------
// Serial IRQ framing
// ----------------------------------------------------------------
`define IDC_SIRQ_SLOTS      5'h15
`define IDC_SIRQ_START_MIN  3'h4

// ----------------------------------------------------------------
// Decode slot (cycles after FRAME# for subtractive claim)
// ----------------------------------------------------------------
`define IDC_SUB_SLOT        3'h4
`define IDC_BIOS_BASE       32'hFFF00000
`define IDC_BIOS_MASK       32'hFFF00000

`endif

// ==== logic/idc_pkg.sv ====
// Types for the ISA DMA and decode control block
// Assumes the defines header sits beside it
package idc_pkg;

    typedef enum logic [1:0]
    {
        IDC_IDLE = 2'h0,
        IDC_REQ  = 2'h1,
        IDC_XFER = 2'h3,
        IDC_DONE = 2'h2
    } idc_dma_st_t;

    typedef enum logic [1:0]
    {
        IDC_SQ_IDLE  = 2'h0,
        IDC_SQ_START = 2'h1,
        IDC_SQ_SLOTS = 2'h3
    } idc_sirq_st_t;

    typedef struct packed
    {
        logic        frame;
        logic        claimed;
        logic [31:0] addr;
    } idc_pci_t;

    typedef struct packed
    {
        idc_dma_st_t  dma_st;
        logic [2:0]   chan;
        logic [7:0]   dack_n;
        logic         tc;
        logic         aen;
        logic         req_n;
        idc_sirq_st_t sq_st;
        logic [2:0]   sq_low;
        logic [4:0]   sq_slot;
        logic [1:0]   sq_phase;
        logic         sq_out;
        logic         sq_oe;
        logic         strap_done;
        logic         bios_pos;
        logic         test_mode;
        logic [2:0]   dec_cnt;
        logic         devsel_n;
        logic         chk_err;
    } idc_state_t;

endpackage

// ==== logic/idc_top.sv ====
// ISA DMA handshake, serial IRQ slave, decode and PC/PCI request control
// Assumes pin inputs are asynchronous and pass two flip-flops here, except i_last_xfer, i_xfer_done and i_pci
`timescale 1ns/1ps
`include "idc_defs.svh"

module idc_top
(
    // Clock and reset
    input  wire logic            i_core_clk,
    input  wire logic            i_nrst,
    // ISA DMA and master
    input  wire logic [7:0]      i_dma_req,
    input  wire logic            i_isa_master_req,
    input  wire logic            i_last_xfer,
    input  wire logic            i_xfer_done,
    input  wire logic            i_io_chk_n,
    input  wire logic [15:0]     i_irq,
    output logic [7:0]           o_dack_n,
    output logic                 o_tc,
    output logic                 o_aen,
    output logic                 o_io_chk_err,
    // PC/PCI arbitration
    output logic                 o_pcpci_bus_request_n,
    input  wire logic            i_pcpci_bus_grant_n,
    // Decode
    input  wire idc_pkg::idc_pci_t i_pci,
    input  wire logic            i_prohibit,
    input  wire logic            i_bios_positive_decode_strap_n,
    input  wire logic            i_ale,
    output logic                 o_devsel_n,
    output logic                 o_bios_pos,
    output logic                 o_test_mode,
    // Serial IRQ pin
    input  wire logic            i_serirq,
    output logic                 o_serirq,
    output logic                 o_serirq_oe
);
    import idc_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    localparam int SW = 8 + 1 + 1 + 16 + 1 + 1 + 1 + 1 + 1;
    // Idle pin levels, so no false error, grant or frame start follows reset
    localparam logic [SW-1:0] SYNC_IDLE = {8'h00, 1'b0, 1'b1, 16'h0000, 1'b1, 1'b1, 1'b1,
                                           1'b0, 1'b1};
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    wire  [SW-1:0] raw = {i_dma_req, i_isa_master_req, i_io_chk_n, i_irq,
                          i_pcpci_bus_grant_n, i_prohibit,
                          i_bios_positive_decode_strap_n, i_ale, i_serirq};
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
        end
        else
        begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end
    logic [7:0]  dreq;
    logic        mreq;
    logic        chk_n;
    logic [15:0] irq;
    logic        gnt_n;
    logic        prohibit;
    logic        bpd_n;
    logic        ale;
    logic        sirq_in;
    assign {dreq, mreq, chk_n, irq, gnt_n, prohibit, bpd_n, ale, sirq_in} = sync2;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    idc_state_t st;
    idc_state_t next_st;
    logic [7:0] dreq_v;
    logic [15:0] irq_v;
    logic [2:0] pick;
    logic       pick_ok;
    logic       in_bios;

    always_comb
    begin
        dreq_v  = dreq & `IDC_DMA_CH_MASK;
        irq_v   = irq & `IDC_IRQ_MASK;
        pick    = `IDC_DMA_NONE;
        pick_ok = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            if (dreq_v[i])
            begin
                pick    = 3'(i);
                pick_ok = 1'b1;
            end
        end
        in_bios = (i_pci.addr & `IDC_BIOS_MASK) == `IDC_BIOS_BASE;
        next_st = st;

        // DMA sequencer
        unique case (st.dma_st)
            IDC_IDLE:
            begin
                if (pick_ok || mreq)
                begin
                    next_st.req_n  = 1'b0;
                    next_st.chan   = pick;
                    next_st.dma_st = IDC_REQ;
                end
            end
            IDC_REQ:
            begin
                if (!gnt_n)
                begin
                    next_st.req_n  = 1'b1;
                    next_st.dma_st = IDC_XFER;
                    if (st.chan != `IDC_DMA_NONE)
                    begin
                        next_st.dack_n[st.chan] = 1'b0;
                        next_st.aen = 1'b1;
                        next_st.tc  = i_last_xfer;
                    end
                end
            end
            IDC_XFER:
            begin
                next_st.tc = i_last_xfer && st.chan != `IDC_DMA_NONE;
                if (i_xfer_done || (st.chan == `IDC_DMA_NONE && !mreq))
                begin
                    next_st.dma_st = IDC_DONE;
                    next_st.dack_n = 8'hFF;
                    next_st.aen    = 1'b0;
                    next_st.tc     = 1'b0;
                end
            end
            IDC_DONE:
            begin
                next_st.dma_st = IDC_IDLE;
            end
        endcase

        // Channel check error, set wins over nothing; cleared by reset
        if (!chk_n)
        begin
            next_st.chk_err = 1'b1;
        end

        // Strap capture at first latch-enable high after reset
        if (!st.strap_done && ale)
        begin
            next_st.strap_done = 1'b1;
            next_st.bios_pos   = !bpd_n;
            next_st.test_mode  = prohibit;
        end

        // Decode claim
        next_st.devsel_n = 1'b1;
        if (!i_pci.frame)
        begin
            next_st.dec_cnt = '0;
        end
        else if (st.dec_cnt != `IDC_SUB_SLOT)
        begin
            next_st.dec_cnt = st.dec_cnt + 3'h1;
        end
        if (i_pci.frame && st.bios_pos && in_bios && st.dec_cnt == 3'h0)
        begin
            next_st.devsel_n = 1'b0;
        end
        else if (i_pci.frame && st.dec_cnt == `IDC_SUB_SLOT - 3'h1 && !i_pci.claimed
                 && !(st.bios_pos && in_bios)
                 && (!prohibit || st.bios_pos))
        begin
            next_st.devsel_n = 1'b0;
        end

        // Serial IRQ slave, one sample per slot phase of three clocks
        next_st.sq_oe  = 1'b0;
        next_st.sq_out = 1'b1;
        unique case (st.sq_st)
            IDC_SQ_IDLE:
            begin
                // Saturate, so a long start frame still counts as one
                next_st.sq_low = sirq_in ? 3'h0
                               : (st.sq_low == 3'h7) ? 3'h7 : st.sq_low + 3'h1;
                if (sirq_in && st.sq_low >= `IDC_SIRQ_START_MIN)
                begin
                    next_st.sq_st    = IDC_SQ_SLOTS;
                    next_st.sq_slot  = '0;
                    next_st.sq_phase = 2'h1;
                end
                else if (!sirq_in && st.sq_low == 3'h0 && |irq_v)
                begin
                    next_st.sq_st = IDC_SQ_START;          // quiet mode start
                end
            end
            IDC_SQ_START:
            begin
                next_st.sq_st  = IDC_SQ_IDLE;
                next_st.sq_low = 3'h1;
            end
            IDC_SQ_SLOTS:
            begin
                next_st.sq_phase = (st.sq_phase == 2'h2) ? 2'h0 : st.sq_phase + 2'h1;
                if (st.sq_phase == 2'h2)
                begin
                    next_st.sq_slot = st.sq_slot + 5'h1;
                end
                if (st.sq_slot == `IDC_SIRQ_SLOTS)
                begin
                    next_st.sq_st  = IDC_SQ_IDLE;
                    next_st.sq_low = 3'h0;
                end
                else if (st.sq_phase == 2'h2 && st.sq_slot < 5'h0F
                         && irq_v[4'(st.sq_slot + 5'h1)])
                begin
                    next_st.sq_out = 1'b0;
                    next_st.sq_oe  = 1'b1;
                end
                else if (st.sq_oe && !st.sq_out)
                begin
                    next_st.sq_out = 1'b1;                 // recovery drive high
                    next_st.sq_oe  = 1'b1;
                end
            end
            default:
            begin
                next_st.sq_st = IDC_SQ_IDLE;
            end
        endcase
        if (st.sq_st == IDC_SQ_START)
        begin
            next_st.sq_out = 1'b0;
            next_st.sq_oe  = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st          <= '0;
            st.dma_st   <= IDC_IDLE;
            st.sq_st    <= IDC_SQ_IDLE;
            st.dack_n   <= 8'hFF;
            st.req_n    <= 1'b1;
            st.sq_out   <= 1'b1;
            st.devsel_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_dack_n              = st.dack_n;
    assign o_tc                  = st.tc;
    assign o_aen                 = st.aen;
    assign o_io_chk_err          = st.chk_err;
    assign o_pcpci_bus_request_n = st.req_n;
    assign o_devsel_n            = st.devsel_n;
    assign o_bios_pos            = st.bios_pos;
    assign o_test_mode           = st.test_mode;
    assign o_serirq              = st.sq_out;
    assign o_serirq_oe           = st.sq_oe;
endmodule
